/* File: interrupt_priority_regs_tb.sv */
// Self-checking bench: bus tasks, a field model and the scenarios.
// Assumes the design, source model and checker are compiled first.
`default_nettype none

module interrupt_priority_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic [15:0] pattern = 16'h0;
    logic [31:0] seed = 32'h483E6CCC;
    wire logic awready, wready, bvalid, arready, rvalid;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [15:0] srcFlag, srcRequest;
    wire logic [2:0] lvl [16];
    logic [15:0] model [8];
    logic [15:0] mask [8] = '{default: 16'h0000};
    logic [7:0] addr [8] = '{8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h30, 8'h3C, 8'h40};
    int srcReg [16] = '{0, 1, 1, 2, 2, 2, 2, 3, 3, 4, 5, 5, 6, 7, 7, 7};
    int srcLsb [16] = '{0, 12, 4, 12, 8, 4, 0, 4, 0, 4, 8, 4, 8, 12, 8, 4};
    int errorCnt = 0, nChecks = 0, cycles = 0;

    ipr_regs_top dut (
        .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .srcFlag(srcFlag), .srcRequest(srcRequest), .ext_int1_level(lvl[0]),
        .timer4_level(lvl[1]), .compare3_level(lvl[2]), .serial2_tx_level(lvl[3]),
        .serial2_rx_level(lvl[4]), .ext_int2_level(lvl[5]), .timer5_level(lvl[6]),
        .spi2_event_level(lvl[7]), .spi2_fault_level(lvl[8]), .capture3_level(lvl[9]),
        .i2c2_master_level(lvl[10]), .i2c2_slave_level(lvl[11]), .calendar_level(lvl[12]),
        .crc_error_level(lvl[13]), .serial2_error_level(lvl[14]),
        .serial1_error_level(lvl[15])
    );

    ipr_src_model srcs (.clk(clk), .rst(rst), .pattern(pattern), .srcFlag(srcFlag));

    initial
    begin
        forever #50 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        nChecks++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // slow: ready only after valid seen
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic slow, output logic [31:0] q, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= w;
        wvalid <= w;
        arvalid <= !w;
        bready <= w && !slow;
        rready <= !w && !slow;
        do
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (arready)
                arvalid <= 1'b0;
            bready <= w && (bvalid || !slow);
            rready <= !w && (rvalid || !slow);
        end while (!(bvalid && bready) && !(rvalid && rready));
        q = rdata;
        r = w ? bresp : rresp;
    endtask

    task automatic wr(input int i, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        logic [1:0] r;
        xfer(1'b1, addr[i], d, s, d[31], q, r);
        check({30'h0, r}, 32'h0, "write resp");
        if (s[0])
            model[i][7:0] = d[7:0] & mask[i][7:0];
        if (s[1])
            model[i][15:8] = d[15:8] & mask[i][15:8];
    endtask

    task automatic reset_model();
        for (int i = 0; i < 8; i++)
            model[i] = 16'h0000;
        for (int j = 0; j < 16; j++)
            model[srcReg[j]][srcLsb[j] +: 3] = 3'h4;
    endtask

    task automatic chk_all();
        logic [31:0] q;
        logic [1:0] r;
        logic [2:0] f;
        logic [15:0] en;
        for (int i = 0; i < 8; i++)
        begin
            xfer(1'b0, addr[i], 32'h0, 4'h0, seed[i], q, r);
            check({30'h0, r}, 32'h0, "read resp");
            check(q, {16'h0, model[i]}, "read data");
        end
        seed = lfsr(seed);
        pattern <= seed[15:0];
        repeat (3) @(posedge clk);
        for (int j = 0; j < 16; j++)
        begin
            f = model[srcReg[j]][srcLsb[j] +: 3];
            en[j] = f != 3'h0;
            check({29'h0, lvl[j]}, {29'h0, f}, "level");
        end
        check({16'h0, srcRequest}, {16'h0, seed[15:0] & en}, "request");
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            errorCnt++;
            $display("unexpected at %0t: run too long", $time);
            give_verdict();
        end
    end

    initial
    begin
        logic [31:0] q;
        logic [1:0] r;
        for (int j = 0; j < 16; j++)
            mask[srcReg[j]] = mask[srcReg[j]] | (16'h0007 << srcLsb[j]);
        reset_model();
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        chk_all();
        $display("reset done");
        for (int i = 0; i < 8; i++)
            wr(i, 32'hFFFFFFFF, 4'hF);
        chk_all();
        $display("ones done");
        repeat (24)
        begin
            seed = lfsr(seed);
            wr(int'(seed[2:0]), lfsr(seed), seed[7:4]);
            chk_all();
        end
        $display("random done");
        xfer(1'b1, 8'h15, 32'hFFFFFFFF, 4'hF, 1'b0, q, r);
        check({30'h0, r}, 32'h2, "misaligned write");
        xfer(1'b0, 8'h44, 32'h0, 4'h0, 1'b1, q, r);
        check({30'h0, r}, 32'h2, "unmapped read resp");
        check(q, 32'h0, "unmapped read data");
        chk_all();
        $display("unmapped done");
        for (int i = 0; i < 8; i++)
            wr(i, 32'h0, 4'h3);
        chk_all();
        $display("disabled done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        reset_model();
        chk_all();
        $display("reset2 done");
        give_verdict();
    end
endmodule

`default_nettype wire

/* File: ipr_axil_slave.sv */
// AXI4-Lite slave front end: turns bus transfers into one-cycle write and read strobes.
// Assumes the register store answers wrOk, rdOk and rdData combinationally.
`default_nettype none

module ipr_axil_slave #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wrEn,
    output logic [ADDR_W-1:0] wrAddr,
    output logic [31:0] wrData,
    output logic [3:0] wrStrb,
    input wire logic wrOk,
    output logic rdEn,
    output logic [ADDR_W-1:0] rdAddr,
    input wire logic rdOk,
    input wire logic [31:0] rdData
);

    ipr_pkg::ipr_wr_state_t wrState, next_wrState;
    ipr_pkg::ipr_rd_state_t rdState, next_rdState;
    logic awHeld, next_awHeld;
    logic wHeld, next_wHeld;
    logic [ADDR_W-1:0] next_wrAddr;
    logic [31:0] next_wrData;
    logic [3:0] next_wrStrb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;

    always_comb
    begin
        next_wrState = wrState;
        next_awHeld = awHeld;
        next_wHeld = wHeld;
        next_wrAddr = wrAddr;
        next_wrData = wrData;
        next_wrStrb = wrStrb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        wrEn = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_awHeld = 1'b1;
            next_wrAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_wHeld = 1'b1;
            next_wrData = s_axi_wdata;
            next_wrStrb = s_axi_wstrb;
        end
        unique case (wrState)
            ipr_pkg::WR_COLLECT:
            begin
                if (awHeld && wHeld)
                begin
                    wrEn = 1'b1;
                    next_bresp = wrOk ? ipr_pkg::RESP_OKAY : ipr_pkg::RESP_SLVERR;
                    next_bvalid = 1'b1;
                    next_awHeld = 1'b0;
                    next_wHeld = 1'b0;
                    next_wrState = ipr_pkg::WR_RESP;
                end
            end
            ipr_pkg::WR_RESP:
            begin
                if (s_axi_bready)
                begin
                    next_bvalid = 1'b0;
                    next_wrState = ipr_pkg::WR_COLLECT;
                end
            end
        endcase
        next_awready = (next_wrState == ipr_pkg::WR_COLLECT) && !next_awHeld
            && !(awHeld && wHeld);
        next_wready = (next_wrState == ipr_pkg::WR_COLLECT) && !next_wHeld
            && !(awHeld && wHeld);
    end

    // read address is held by the master while arvalid stands
    assign rdAddr = s_axi_araddr;

    always_comb
    begin
        next_rdState = rdState;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_arready = s_axi_arready;
        rdEn = 1'b0;
        unique case (rdState)
            ipr_pkg::RD_IDLE:
            begin
                next_arready = 1'b1;
                if (s_axi_arvalid && s_axi_arready)
                begin
                    rdEn = 1'b1;
                    next_rdata = rdOk ? rdData : 32'h0000_0000;
                    next_rresp = rdOk ? ipr_pkg::RESP_OKAY : ipr_pkg::RESP_SLVERR;
                    next_rvalid = 1'b1;
                    next_arready = 1'b0;
                    next_rdState = ipr_pkg::RD_RESP;
                end
            end
            ipr_pkg::RD_RESP:
            begin
                if (s_axi_rready)
                begin
                    next_rvalid = 1'b0;
                    next_arready = 1'b1;
                    next_rdState = ipr_pkg::RD_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wrState <= ipr_pkg::WR_COLLECT;
            rdState <= ipr_pkg::RD_IDLE;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            wrAddr <= '0;
            wrData <= 32'h0000_0000;
            wrStrb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end
        else
        begin
            wrState <= next_wrState;
            rdState <= next_rdState;
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            wrAddr <= next_wrAddr;
            wrData <= next_wrData;
            wrStrb <= next_wrStrb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

endmodule

`default_nettype wire

/* File: ipr_pkg.sv */
// Constants, field layout, address map and state types for the interrupt priority bank.
// Assumes a single 10 MHz clock and an AXI4-Lite master on the register side.
// Overview of operation
// - three-bit field is the level in binary
// - field value zero disables that source's request
// - unassigned bits ignore writes, read zero
// - reset loads each field as binary 100
// - field bits read back last written value
// - ext int1 level in bits 2-0
// - timer4 14-12, compare3 6-4
// - serial2 tx, rx, ext int2, timer5
// - spi2 event 6-4, fault 2-0
// - capture3 level in bits 6-4
// - i2c2 master 10-8, slave 6-4
// - calendar level in bits 10-8
// - crc, serial2 error, serial1 error fields
// - every source starts at level four
`default_nettype none

package ipr_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int LVL_W = 3;
    localparam int NUM_REGS = 8;
    localparam int NUM_SRC = 16;

    // byte addresses of the priority words
    localparam logic [7:0] OFF_EXT_INT1 = 8'h14;
    localparam logic [7:0] OFF_TIMER4_OC3 = 8'h18;
    localparam logic [7:0] OFF_SERIAL2_INT2_TIMER5 = 8'h1C;
    localparam logic [7:0] OFF_SPI2 = 8'h20;
    localparam logic [7:0] OFF_CAPTURE3 = 8'h24;
    localparam logic [7:0] OFF_I2C2 = 8'h30;
    localparam logic [7:0] OFF_RTC = 8'h3C;
    localparam logic [7:0] OFF_CRC_SERIAL_ERR = 8'h40;

    // storage slots
    localparam logic [3:0] SLOT_EXT_INT1 = 4'h0;
    localparam logic [3:0] SLOT_TIMER4_OC3 = 4'h1;
    localparam logic [3:0] SLOT_SERIAL2_INT2_TIMER5 = 4'h2;
    localparam logic [3:0] SLOT_SPI2 = 4'h3;
    localparam logic [3:0] SLOT_CAPTURE3 = 4'h4;
    localparam logic [3:0] SLOT_I2C2 = 4'h5;
    localparam logic [3:0] SLOT_RTC = 4'h6;
    localparam logic [3:0] SLOT_CRC_SERIAL_ERR = 4'h7;
    localparam logic [3:0] SLOT_NONE = 4'h8;

    // implemented bits per word
    localparam logic [15:0] MASK_EXT_INT1 = 16'h0007;
    localparam logic [15:0] MASK_TIMER4_OC3 = 16'h7070;
    localparam logic [15:0] MASK_SERIAL2_INT2_TIMER5 = 16'h7777;
    localparam logic [15:0] MASK_SPI2 = 16'h0077;
    localparam logic [15:0] MASK_CAPTURE3 = 16'h0070;
    localparam logic [15:0] MASK_I2C2 = 16'h0770;
    localparam logic [15:0] MASK_RTC = 16'h0700;
    localparam logic [15:0] MASK_CRC_SERIAL_ERR = 16'h7770;

    // every field resets to binary 100, level four
    localparam logic [15:0] FIELD_RESET_PATTERN = 16'h4444;
    localparam logic [2:0] LEVEL_OFF = 3'h0;

    // field positions
    localparam int FLD3_LSB = 12;
    localparam int FLD2_LSB = 8;
    localparam int FLD1_LSB = 4;
    localparam int FLD0_LSB = 0;

    // source numbering on the request vector
    localparam int SRC_EXT_INT1 = 0;
    localparam int SRC_TIMER4 = 1;
    localparam int SRC_COMPARE3 = 2;
    localparam int SRC_SERIAL2_TX = 3;
    localparam int SRC_SERIAL2_RX = 4;
    localparam int SRC_EXT_INT2 = 5;
    localparam int SRC_TIMER5 = 6;
    localparam int SRC_SPI2_EVENT = 7;
    localparam int SRC_SPI2_FAULT = 8;
    localparam int SRC_CAPTURE3 = 9;
    localparam int SRC_I2C2_MASTER = 10;
    localparam int SRC_I2C2_SLAVE = 11;
    localparam int SRC_CALENDAR = 12;
    localparam int SRC_CRC_ERROR = 13;
    localparam int SRC_SERIAL2_ERROR = 14;
    localparam int SRC_SERIAL1_ERROR = 15;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {WR_COLLECT = 1'b0, WR_RESP = 1'b1} ipr_wr_state_t;
    typedef enum logic [0:0] {RD_IDLE = 1'b0, RD_RESP = 1'b1} ipr_rd_state_t;

    function automatic logic [3:0] ipr_slot(input logic [7:0] addr);
        unique case (addr)
            OFF_EXT_INT1: ipr_slot = SLOT_EXT_INT1;
            OFF_TIMER4_OC3: ipr_slot = SLOT_TIMER4_OC3;
            OFF_SERIAL2_INT2_TIMER5: ipr_slot = SLOT_SERIAL2_INT2_TIMER5;
            OFF_SPI2: ipr_slot = SLOT_SPI2;
            OFF_CAPTURE3: ipr_slot = SLOT_CAPTURE3;
            OFF_I2C2: ipr_slot = SLOT_I2C2;
            OFF_RTC: ipr_slot = SLOT_RTC;
            OFF_CRC_SERIAL_ERR: ipr_slot = SLOT_CRC_SERIAL_ERR;
            default: ipr_slot = SLOT_NONE;
        endcase
    endfunction

    function automatic logic [15:0] ipr_mask(input logic [3:0] slot);
        unique case (slot)
            SLOT_EXT_INT1: ipr_mask = MASK_EXT_INT1;
            SLOT_TIMER4_OC3: ipr_mask = MASK_TIMER4_OC3;
            SLOT_SERIAL2_INT2_TIMER5: ipr_mask = MASK_SERIAL2_INT2_TIMER5;
            SLOT_SPI2: ipr_mask = MASK_SPI2;
            SLOT_CAPTURE3: ipr_mask = MASK_CAPTURE3;
            SLOT_I2C2: ipr_mask = MASK_I2C2;
            SLOT_RTC: ipr_mask = MASK_RTC;
            SLOT_CRC_SERIAL_ERR: ipr_mask = MASK_CRC_SERIAL_ERR;
            default: ipr_mask = 16'h0000;
        endcase
    endfunction

endpackage

`default_nettype wire

/* File: ipr_regs_top.sv */
// Interrupt priority bank: eight 16-bit priority words, per-source levels and gated requests.
// Assumes source flags are synchronous to clk; registers are reached over AXI4-Lite.
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`default_nettype none

module ipr_regs_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] srcFlag,
    output logic [15:0] srcRequest,
    output logic [2:0] ext_int1_level,
    output logic [2:0] timer4_level,
    output logic [2:0] compare3_level,
    output logic [2:0] serial2_tx_level,
    output logic [2:0] serial2_rx_level,
    output logic [2:0] ext_int2_level,
    output logic [2:0] timer5_level,
    output logic [2:0] spi2_event_level,
    output logic [2:0] spi2_fault_level,
    output logic [2:0] capture3_level,
    output logic [2:0] i2c2_master_level,
    output logic [2:0] i2c2_slave_level,
    output logic [2:0] calendar_level,
    output logic [2:0] crc_error_level,
    output logic [2:0] serial2_error_level,
    output logic [2:0] serial1_error_level
);

    logic wrEn;
    logic [7:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic rdEn;
    logic [7:0] rdAddr;
    logic [3:0] wrSlot, rdSlot;
    logic wrOk, rdOk;
    logic [31:0] rdData;
    logic [15:0] laneMask;
    logic [15:0] prio [ipr_pkg::NUM_REGS];
    logic [15:0] next_prio [ipr_pkg::NUM_REGS];
    logic [2:0] lvl [ipr_pkg::NUM_SRC];
    logic [15:0] next_srcRequest;

    ipr_axil_slave #(
        .ADDR_W(ipr_pkg::ADDR_W)
    ) u_bus (
        .clk(clk),
        .rst(rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .wrStrb(wrStrb),
        .wrOk(wrOk),
        .rdEn(rdEn),
        .rdAddr(rdAddr),
        .rdOk(rdOk),
        .rdData(rdData)
    );

    // address decode; unmapped words answer with an error
    assign wrSlot = ipr_pkg::ipr_slot(wrAddr);
    assign rdSlot = ipr_pkg::ipr_slot(rdAddr);
    assign wrOk = (wrSlot != ipr_pkg::SLOT_NONE);
    assign rdOk = (rdSlot != ipr_pkg::SLOT_NONE);

    // only the two low byte lanes carry register bits
    assign laneMask = {{8{wrStrb[1]}}, {8{wrStrb[0]}}};

    // stored words never hold unimplemented bits, so reads return them as zero
    always_comb
    begin
        rdData = 32'h0000_0000;
        if (rdEn && rdOk)
        begin
            rdData = {16'h0000, prio[rdSlot[2:0]]};
        end
    end

    always_comb
    begin
        for (int i = 0; i < ipr_pkg::NUM_REGS; i++)
        begin
            next_prio[i] = prio[i];
        end
        if (wrEn && wrOk)
        begin
            next_prio[wrSlot[2:0]] = ((prio[wrSlot[2:0]] & ~laneMask)
                | (wrData[15:0] & laneMask)) & ipr_pkg::ipr_mask(wrSlot);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < ipr_pkg::NUM_REGS; i++)
            begin
                // each field loads binary 100
                prio[i] <= ipr_pkg::FIELD_RESET_PATTERN
                    & ipr_pkg::ipr_mask(4'(i));
            end
        end
        else
        begin
            for (int i = 0; i < ipr_pkg::NUM_REGS; i++)
            begin
                prio[i] <= next_prio[i];
            end
        end
    end

    // field placement within each word
    assign lvl[ipr_pkg::SRC_EXT_INT1] =
        prio[ipr_pkg::SLOT_EXT_INT1[2:0]][ipr_pkg::FLD0_LSB +: 3];
    assign lvl[ipr_pkg::SRC_TIMER4] =
        prio[ipr_pkg::SLOT_TIMER4_OC3[2:0]][ipr_pkg::FLD3_LSB +: 3];
    assign lvl[ipr_pkg::SRC_COMPARE3] =
        prio[ipr_pkg::SLOT_TIMER4_OC3[2:0]][ipr_pkg::FLD1_LSB +: 3];
    assign lvl[ipr_pkg::SRC_SERIAL2_TX] =
        prio[ipr_pkg::SLOT_SERIAL2_INT2_TIMER5[2:0]][ipr_pkg::FLD3_LSB +: 3];
    assign lvl[ipr_pkg::SRC_SERIAL2_RX] =
        prio[ipr_pkg::SLOT_SERIAL2_INT2_TIMER5[2:0]][ipr_pkg::FLD2_LSB +: 3];
    assign lvl[ipr_pkg::SRC_EXT_INT2] =
        prio[ipr_pkg::SLOT_SERIAL2_INT2_TIMER5[2:0]][ipr_pkg::FLD1_LSB +: 3];
    assign lvl[ipr_pkg::SRC_TIMER5] =
        prio[ipr_pkg::SLOT_SERIAL2_INT2_TIMER5[2:0]][ipr_pkg::FLD0_LSB +: 3];
    assign lvl[ipr_pkg::SRC_SPI2_EVENT] =
        prio[ipr_pkg::SLOT_SPI2[2:0]][ipr_pkg::FLD1_LSB +: 3];
    assign lvl[ipr_pkg::SRC_SPI2_FAULT] =
        prio[ipr_pkg::SLOT_SPI2[2:0]][ipr_pkg::FLD0_LSB +: 3];
    assign lvl[ipr_pkg::SRC_CAPTURE3] =
        prio[ipr_pkg::SLOT_CAPTURE3[2:0]][ipr_pkg::FLD1_LSB +: 3];
    assign lvl[ipr_pkg::SRC_I2C2_MASTER] =
        prio[ipr_pkg::SLOT_I2C2[2:0]][ipr_pkg::FLD2_LSB +: 3];
    assign lvl[ipr_pkg::SRC_I2C2_SLAVE] =
        prio[ipr_pkg::SLOT_I2C2[2:0]][ipr_pkg::FLD1_LSB +: 3];
    assign lvl[ipr_pkg::SRC_CALENDAR] =
        prio[ipr_pkg::SLOT_RTC[2:0]][ipr_pkg::FLD2_LSB +: 3];
    assign lvl[ipr_pkg::SRC_CRC_ERROR] =
        prio[ipr_pkg::SLOT_CRC_SERIAL_ERR[2:0]][ipr_pkg::FLD3_LSB +: 3];
    assign lvl[ipr_pkg::SRC_SERIAL2_ERROR] =
        prio[ipr_pkg::SLOT_CRC_SERIAL_ERR[2:0]][ipr_pkg::FLD2_LSB +: 3];
    assign lvl[ipr_pkg::SRC_SERIAL1_ERROR] =
        prio[ipr_pkg::SLOT_CRC_SERIAL_ERR[2:0]][ipr_pkg::FLD1_LSB +: 3];

    // levels go straight from the storage flops to arbitration, binary coded
    assign ext_int1_level = lvl[ipr_pkg::SRC_EXT_INT1];
    assign timer4_level = lvl[ipr_pkg::SRC_TIMER4];
    assign compare3_level = lvl[ipr_pkg::SRC_COMPARE3];
    assign serial2_tx_level = lvl[ipr_pkg::SRC_SERIAL2_TX];
    assign serial2_rx_level = lvl[ipr_pkg::SRC_SERIAL2_RX];
    assign ext_int2_level = lvl[ipr_pkg::SRC_EXT_INT2];
    assign timer5_level = lvl[ipr_pkg::SRC_TIMER5];
    assign spi2_event_level = lvl[ipr_pkg::SRC_SPI2_EVENT];
    assign spi2_fault_level = lvl[ipr_pkg::SRC_SPI2_FAULT];
    assign capture3_level = lvl[ipr_pkg::SRC_CAPTURE3];
    assign i2c2_master_level = lvl[ipr_pkg::SRC_I2C2_MASTER];
    assign i2c2_slave_level = lvl[ipr_pkg::SRC_I2C2_SLAVE];
    assign calendar_level = lvl[ipr_pkg::SRC_CALENDAR];
    assign crc_error_level = lvl[ipr_pkg::SRC_CRC_ERROR];
    assign serial2_error_level = lvl[ipr_pkg::SRC_SERIAL2_ERROR];
    assign serial1_error_level = lvl[ipr_pkg::SRC_SERIAL1_ERROR];

    // a source with level zero never requests
    always_comb
    begin
        for (int i = 0; i < ipr_pkg::NUM_SRC; i++)
        begin
            next_srcRequest[i] = srcFlag[i] && (lvl[i] != ipr_pkg::LEVEL_OFF);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            srcRequest <= 16'h0000;
        end
        else
        begin
            srcRequest <= next_srcRequest;
        end
    end

endmodule

`default_nettype wire

/* File: ipr_regs_top_sva.sv */
// Checker for the priority bank: bus timing, reset levels, gating.
// Assumes one clock and synchronous active-high reset.
`default_nettype none

module ipr_regs_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] srcFlag,
    input wire logic [15:0] srcRequest,
    input wire logic [2:0] ext_int1_level,
    input wire logic [2:0] timer4_level,
    input wire logic [2:0] compare3_level,
    input wire logic [2:0] serial2_tx_level,
    input wire logic [2:0] serial2_rx_level,
    input wire logic [2:0] ext_int2_level,
    input wire logic [2:0] timer5_level,
    input wire logic [2:0] spi2_event_level,
    input wire logic [2:0] spi2_fault_level,
    input wire logic [2:0] capture3_level,
    input wire logic [2:0] i2c2_master_level,
    input wire logic [2:0] i2c2_slave_level,
    input wire logic [2:0] calendar_level,
    input wire logic [2:0] crc_error_level,
    input wire logic [2:0] serial2_error_level,
    input wire logic [2:0] serial1_error_level
);
    logic [47:0] allLv;
    logic [15:0] gateVec;

    assign allLv = {serial1_error_level, serial2_error_level, crc_error_level, calendar_level,
        i2c2_slave_level, i2c2_master_level, capture3_level, spi2_fault_level,
        spi2_event_level, timer5_level, ext_int2_level, serial2_rx_level, serial2_tx_level,
        compare3_level, timer4_level, ext_int1_level};

    always_comb
        for (int i = 0; i < 16; i++)
            gateVec[i] = srcFlag[i] && (allLv[3*i +: 3] != 3'h0);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    reset_levels_a: assert property ($fell(rst) |-> allLv == {16{3'h4}})
        else $error("reset level");
    req_gate_a: assert property (1'b1 |=> srcRequest == $past(gateVec))
        else $error("req gate");
    lvl_hold_a: assert property (!s_axi_bvalid |-> $stable(allLv))
        else $error("level moved");
    b_after_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("b late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("b dropped");
    r_next_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("r late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata))
        else $error("r not held");
    rdata_hi_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("rdata high");
endmodule

bind ipr_regs_top ipr_regs_sva u_sva (.*);

`default_nettype wire

/* File: ipr_src_model.sv */
// Far-side model: peripheral sources raising level request flags.
// Assumes the bench hands it a new pattern just after a clock edge.
`default_nettype none

module ipr_src_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] pattern,
    output logic [15:0] srcFlag
);
    logic [15:0] next_srcFlag;

    always_comb
        next_srcFlag = rst ? 16'h0000 : pattern;

    always_ff @(posedge clk)
        srcFlag <= next_srcFlag;
endmodule

`default_nettype wire
